// >>> shared/mcf_pkg.sv
package mcf_pkg;
    // ----------------------------------------
    // fabric sizes
    // ----------------------------------------
    localparam int MC_NUM    = 16;
    localparam int PT_PER_MC = 5;
    localparam int EXP_NUM   = 16;
    localparam int PT_NUM    = MC_NUM * PT_PER_MC + EXP_NUM;
    localparam int ROW_IN_N  = 33;
    localparam int ARR_W     = 2 * (ROW_IN_N + MC_NUM) + EXP_NUM;
    localparam int COL_N     = 48;
    localparam int ROW_OUT_N = 32;
    localparam int ROW_PINS  = 8;
    localparam int COL_PINS  = 10;
    localparam int ROW_PICK  = 10;
    localparam int COL_PICK  = 17;
    localparam int ROW_STEP  = 4;
    localparam int COL_STEP  = 5;
    localparam int DED_N     = 4;
    localparam int DED_GCLK0 = 0;
    localparam int DED_GCLR  = 2;

    // ----------------------------------------
    // peripheral control bus layout
    // ----------------------------------------
    localparam int OE_LO  = 0;
    localparam int CLK_LO = 8;
    localparam int CLK_N  = 4;
    localparam int CE_LO  = 12;
    localparam int CE_N   = 6;
    localparam int CLR_LO = 18;
    localparam int PBUS_N = 20;

    // ----------------------------------------
    // register map, word addresses
    // ----------------------------------------
    localparam logic [9:0]  A_PT         = 10'h000;
    localparam logic [9:0]  A_MC         = 10'h200;
    localparam logic [9:0]  A_RMUX       = 10'h210;
    localparam logic [9:0]  A_PIN        = 10'h220;
    localparam logic [9:0]  A_PBUS       = 10'h240;
    localparam logic [9:0]  A_ST_MC      = 10'h260;
    localparam logic [9:0]  A_ST_PIN     = 10'h261;
    localparam logic [31:0] PT_TOP_MASK  = 32'h0003ffff;
    localparam logic [31:0] MC_CFG_MASK  = 32'h000001ff;
    localparam logic [31:0] RMUX_MASK    = 32'h0000000f;
    localparam logic [31:0] PIN_CFG_MASK = 32'h0001ffff;
    localparam logic [31:0] PBUS_MASK    = 32'h0000001f;
    localparam logic [31:0] CFG_RST      = 32'h00000000;

    // ----------------------------------------
    // external programmer budget, smallest part
    // ----------------------------------------
    localparam real PROGRAM_PULSE_TIME_S      = 11.79;
    localparam int  PROGRAM_TEST_CLOCK_CYCLES = 2966000;
    localparam real VERIFY_PULSE_TIME_S       = 0.15;
    localparam int  VERIFY_TEST_CLOCK_CYCLES  = 1806000;

    typedef enum logic [1:0] {MCF_PIN_IN, MCF_PIN_OUT, MCF_PIN_BIDIR, MCF_PIN_OFF} mcf_pin_mode_t;

    typedef struct packed {
        logic [22:0] spare;
        logic        gclr_en;
        logic        gclk_sel;
        logic        borrow;
        logic        pt3_clk;
        logic        pt2_ce;
        logic        pt1_pre;
        logic        pt0_clr;
        logic        invert;
        logic        registered;
    } mcf_mc_cfg_t;

    typedef struct packed {
        logic [14:0]   spare;
        logic          clr_sel;
        logic [2:0]    ce_sel;
        logic [1:0]    clk_sel;
        logic [2:0]    oe_sel;
        logic [4:0]    src;
        logic          use_reg;
        mcf_pin_mode_t mode;
    } mcf_pin_cfg_t;
endpackage

// >>> core/mcf_fabric.sv
`timescale 1ns/100ps
module mcf_fabric
    import mcf_pkg::*;
#(
    parameter int ROW_PIN_N = ROW_PINS,
    parameter int COL_PIN_N = COL_PINS
) (
    input  logic                       core_clk,
    input  logic                       rst,
    input  logic [9:0]                 reg_addr,
    input  logic [31:0]                reg_wdata,
    input  logic                       reg_wr,
    input  logic                       reg_rd,
    output logic [31:0]                reg_rdata,
    input  logic [DED_N-1:0]           ded_in,
    input  logic [ROW_IN_N-1:0]        row_in,
    input  logic [COL_N-1:0]           col_in,
    output logic [ROW_OUT_N-1:0]       row_out,
    output logic [MC_NUM-1:0]          mc_out,
    input  logic [ROW_PIN_N+COL_PIN_N-1:0] pin_in,
    output logic [ROW_PIN_N+COL_PIN_N-1:0] pin_o,
    output logic [ROW_PIN_N+COL_PIN_N-1:0] pin_oe,
    output logic [2*ROW_PIN_N-1:0]     pin_row_chan,
    output logic [2*COL_PIN_N-1:0]     pin_col_chan
);
    localparam int PIN_N = ROW_PIN_N + COL_PIN_N;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic in_win(input logic [9:0] a, input logic [9:0] base, input int n);
        return (int'(a) >= int'(base)) && (int'(a) < int'(base) + n);
    endfunction

    function automatic logic pt_eval(input logic [ARR_W-1:0] m, input logic [ARR_W-1:0] v);
        return &(v | ~m);  // empty mask gives one
    endfunction

    function automatic int pick_idx(input int base, input int s, input int lim, input int n);
        return (base + ((s < lim) ? s : 0)) % n;
    endfunction

    logic [ARR_W-1:0]        pt_mask [PT_NUM];
    mcf_mc_cfg_t             mc_cfg [MC_NUM];
    logic [3:0]              rmux [MC_NUM];
    mcf_pin_cfg_t            pin_cfg [PIN_N];
    logic [4:0]              pbus_src [PBUS_N];
    logic [DED_N-1:0]        ded_s1;
    logic [DED_N-1:0]        ded_s2;
    logic [DED_N-1:0]        ded_prev;
    logic [ROW_IN_N-1:0]     row_s1;
    logic [ROW_IN_N-1:0]     row_s2;
    logic [COL_N-1:0]        col_s1;
    logic [COL_N-1:0]        col_s2;
    logic [PIN_N-1:0]        pin_s1;
    logic [PIN_N-1:0]        pin_s2;
    logic [1:0]              gclk_evt;
    logic                    gclr;
    logic [ARR_W-EXP_NUM-1:0] arr_base;
    logic [ARR_W-1:0]        arr;
    logic [EXP_NUM-1:0]      exp_v;
    logic [PT_PER_MC-1:0]    pt_v [MC_NUM];
    logic [MC_NUM-1:0]       own_sum;
    logic [MC_NUM-1:0]       sum_v;
    logic [MC_NUM-1:0]       d_v;
    logic [MC_NUM-1:0]       mc_q;
    logic [MC_NUM-1:0]       mc_regd;
    logic [MC_NUM-1:0]       mc_clr;
    logic [MC_NUM-1:0]       mc_pre;
    logic [MC_NUM-1:0]       mc_ce;
    logic [MC_NUM-1:0]       mc_clk;
    logic [MC_NUM-1:0]       pt3_prev;
    logic [PBUS_N-1:0]       pbus;
    logic [CLK_N-1:0]        pclk_prev;
    logic [CLK_N-1:0]        pclk_evt;
    logic [PIN_N-1:0]        out_src;
    logic [PIN_N-1:0]        p_oe_v;
    logic [PIN_N-1:0]        p_clk_v;
    logic [PIN_N-1:0]        p_ce_v;
    logic [PIN_N-1:0]        p_clr_v;
    logic [PIN_N-1:0]        drive_v;
    logic [PIN_N-1:0]        feeds_v;
    logic [PIN_N-1:0]        pin_val;
    logic [PIN_N-1:0]        pin_reg;
    logic [31:0]             rd_val;

    // ----------------------------------------
    // pin synchronisers and edge history
    // ----------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ded_s1    <= '0;
            ded_s2    <= '0;
            ded_prev  <= '0;
            row_s1    <= '0;
            row_s2    <= '0;
            col_s1    <= '0;
            col_s2    <= '0;
            pin_s1    <= '0;
            pin_s2    <= '0;
            pclk_prev <= '0;
        end else begin
            ded_s1    <= ded_in;
            ded_s2    <= ded_s1;
            ded_prev  <= ded_s2;
            row_s1    <= row_in;
            row_s2    <= row_s1;
            col_s1    <= col_in;
            col_s2    <= col_s1;
            pin_s1    <= pin_in;
            pin_s2    <= pin_s1;
            pclk_prev <= pbus[CLK_LO +: CLK_N];
        end
    end

    // global clocks become one-cycle enables on their rising edge
    assign gclk_evt = ded_s2[DED_GCLK0 +: 2] & ~ded_prev[DED_GCLK0 +: 2];
    assign gclr     = ded_s2[DED_GCLR];

    // ----------------------------------------
    // configuration store
    // ----------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            for (int i = 0; i < PT_NUM; i++) pt_mask[i] <= '0;
            for (int i = 0; i < MC_NUM; i++) begin
                mc_cfg[i] <= mcf_mc_cfg_t'(CFG_RST);
                rmux[i]   <= CFG_RST[3:0];
            end
            for (int i = 0; i < PIN_N; i++) pin_cfg[i] <= mcf_pin_cfg_t'(CFG_RST);
            for (int i = 0; i < PBUS_N; i++) pbus_src[i] <= CFG_RST[4:0];
        end else if (reg_wr) begin
            if (in_win(reg_addr, A_PT, PT_NUM * 4)) begin
                if (reg_addr[1:0] == 2'h3)
                    pt_mask[reg_addr[8:2]][ARR_W-1:96] <= reg_wdata[ARR_W-97:0] & PT_TOP_MASK[ARR_W-97:0];
                else
                    pt_mask[reg_addr[8:2]][reg_addr[1:0]*32 +: 32] <= reg_wdata;
            end
            if (in_win(reg_addr, A_MC, MC_NUM))
                mc_cfg[reg_addr[3:0]] <= mcf_mc_cfg_t'(reg_wdata & MC_CFG_MASK);
            if (in_win(reg_addr, A_RMUX, MC_NUM))
                rmux[reg_addr[3:0]] <= reg_wdata[3:0] & RMUX_MASK[3:0];
            if (in_win(reg_addr, A_PIN, PIN_N))
                pin_cfg[reg_addr[4:0]] <= mcf_pin_cfg_t'(reg_wdata & PIN_CFG_MASK);
            if (in_win(reg_addr, A_PBUS, PBUS_N))
                pbus_src[reg_addr[4:0]] <= reg_wdata[4:0] & PBUS_MASK[4:0];
        end
    end

    // read decode, unmapped reads return zero
    always_comb begin
        rd_val = 32'h00000000;
        if (in_win(reg_addr, A_PT, PT_NUM * 4))
            rd_val = 32'({14'h0000, pt_mask[reg_addr[8:2]]} >> (reg_addr[1:0] * 32));
        else if (in_win(reg_addr, A_MC, MC_NUM))
            rd_val = mc_cfg[reg_addr[3:0]];
        else if (in_win(reg_addr, A_RMUX, MC_NUM))
            rd_val = 32'(rmux[reg_addr[3:0]]);
        else if (in_win(reg_addr, A_PIN, PIN_N))
            rd_val = pin_cfg[reg_addr[4:0]];
        else if (in_win(reg_addr, A_PBUS, PBUS_N))
            rd_val = 32'(pbus_src[reg_addr[4:0]]);
        else if (reg_addr == A_ST_MC)
            rd_val = 32'(mc_q);
        else if (reg_addr == A_ST_PIN)
            rd_val = 32'(pin_val);
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge core_clk) begin
        if (rst)
            reg_rdata <= 32'h00000000;
        else
            reg_rdata <= reg_rd ? rd_val : 32'h00000000;
    end

    // ----------------------------------------
    // local array and product terms
    // ----------------------------------------
    // feedback taken from flops so no combinational loop forms
    assign arr_base = {~mc_q, mc_q, ~row_s2, row_s2};
    assign arr      = {~exp_v, arr_base};

    // expanders see everything except other expanders
    always_comb begin
        for (int k = 0; k < EXP_NUM; k++)
            exp_v[k] = pt_eval(pt_mask[MC_NUM * PT_PER_MC + k], {{EXP_NUM{1'b1}}, arr_base});
    end

    // terms, sums, neighbour borrowing and register controls per macrocell
    always_comb begin
        for (int i = 0; i < MC_NUM; i++) begin
            for (int j = 0; j < PT_PER_MC; j++)
                pt_v[i][j] = pt_eval(pt_mask[i * PT_PER_MC + j], arr);
            own_sum[i] = (pt_v[i][0] & ~mc_cfg[i].pt0_clr) | (pt_v[i][1] & ~mc_cfg[i].pt1_pre)
                       | (pt_v[i][2] & ~mc_cfg[i].pt2_ce) | (pt_v[i][3] & ~mc_cfg[i].pt3_clk)
                       | pt_v[i][4];
            mc_regd[i] = mc_cfg[i].registered;
            mc_clr[i]  = (mc_cfg[i].gclr_en & gclr) | (mc_cfg[i].pt0_clr & pt_v[i][0]);
            mc_pre[i]  = mc_cfg[i].pt1_pre & pt_v[i][1];
            mc_ce[i]   = mc_cfg[i].pt2_ce ? pt_v[i][2] : 1'b1;
            mc_clk[i]  = mc_cfg[i].pt3_clk ? (pt_v[i][3] & ~pt3_prev[i]) : gclk_evt[mc_cfg[i].gclk_sel];
        end
        sum_v[0] = own_sum[0];
        for (int i = 1; i < MC_NUM; i++)
            sum_v[i] = own_sum[i] | (mc_cfg[i].borrow & sum_v[i-1]);
        for (int i = 0; i < MC_NUM; i++)
            d_v[i] = sum_v[i] ^ mc_cfg[i].invert;
    end

    // ----------------------------------------
    // macrocell output flops
    // ----------------------------------------
    // clear beats preset beats the clocked load
    always_ff @(posedge core_clk) begin
        if (rst) begin
            mc_q     <= '0;
            pt3_prev <= '0;
        end else begin
            for (int i = 0; i < MC_NUM; i++) begin
                pt3_prev[i] <= pt_v[i][3];
                if (!mc_regd[i])
                    mc_q[i] <= d_v[i];
                else if (mc_clr[i])
                    mc_q[i] <= 1'b0;
                else if (mc_pre[i])
                    mc_q[i] <= 1'b1;
                else if (mc_clk[i] && mc_ce[i])
                    mc_q[i] <= d_v[i];
            end
        end
    end

    assign mc_out = mc_q;

    // ----------------------------------------
    // row channel selectors
    // ----------------------------------------
    // 4-to-1 shares macrocell with three columns; 3-to-1 reuses them when free
    always_ff @(posedge core_clk) begin
        if (rst) begin
            row_out <= '0;
        end else begin
            for (int i = 0; i < MC_NUM; i++) begin
                if (rmux[i][1:0] == 2'h0) begin
                    row_out[i]          <= mc_q[i];
                    row_out[MC_NUM + i] <= col_s2[3 * i + ((rmux[i][3:2] == 2'h3) ? 0 : int'(rmux[i][3:2]))];
                end else begin
                    row_out[i]          <= col_s2[3 * i + int'(rmux[i][1:0]) - 1];
                    row_out[MC_NUM + i] <= 1'b0;
                end
            end
        end
    end

    // ----------------------------------------
    // peripheral control bus
    // ----------------------------------------
    always_comb begin
        for (int j = 0; j < PBUS_N; j++)
            pbus[j] = pbus_src[j][4] ? mc_q[pbus_src[j][3:0]] : ded_s2[pbus_src[j][1:0]];
    end

    assign pclk_evt = pbus[CLK_LO +: CLK_N] & ~pclk_prev;

    // ----------------------------------------
    // pin cells
    // ----------------------------------------
    always_comb begin
        for (int j = 0; j < PIN_N; j++) begin
            if (j < ROW_PIN_N)
                out_src[j] = row_out[pick_idx(j * ROW_STEP, int'(pin_cfg[j].src), ROW_PICK, ROW_OUT_N)];
            else
                out_src[j] = col_s2[pick_idx((j - ROW_PIN_N) * COL_STEP, int'(pin_cfg[j].src), COL_PICK, COL_N)];
            p_oe_v[j]  = pbus[OE_LO + int'(pin_cfg[j].oe_sel)];
            p_clk_v[j] = pclk_evt[pin_cfg[j].clk_sel];
            p_ce_v[j]  = (int'(pin_cfg[j].ce_sel) < CE_N) ? pbus[CE_LO + int'(pin_cfg[j].ce_sel)] : 1'b1;
            p_clr_v[j] = pbus[CLR_LO + int'(pin_cfg[j].clr_sel)];
            drive_v[j] = (pin_cfg[j].mode == MCF_PIN_OUT)
                       || (pin_cfg[j].mode == MCF_PIN_BIDIR && p_oe_v[j]);
            feeds_v[j] = (pin_cfg[j].mode == MCF_PIN_IN) || (pin_cfg[j].mode == MCF_PIN_BIDIR);
            pin_val[j] = (pin_cfg[j].use_reg && !drive_v[j]) ? pin_reg[j] : pin_s2[j];
        end
    end

    // pin register captures the pin or holds outgoing data
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pin_reg <= '0;
            pin_o   <= '0;
            pin_oe  <= '0;
        end else begin
            for (int j = 0; j < PIN_N; j++) begin
                if (p_clr_v[j])
                    pin_reg[j] <= 1'b0;
                else if (p_clk_v[j] && p_ce_v[j])
                    pin_reg[j] <= drive_v[j] ? out_src[j] : pin_s2[j];
                pin_o[j]  <= pin_cfg[j].use_reg ? pin_reg[j] : out_src[j];
                pin_oe[j] <= drive_v[j];
            end
        end
    end

    // each incoming pin drives a pair of channels
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pin_row_chan <= '0;
            pin_col_chan <= '0;
        end else begin
            for (int j = 0; j < ROW_PIN_N; j++)
                pin_row_chan[2*j +: 2] <= {2{feeds_v[j] & pin_val[j]}};
            for (int j = 0; j < COL_PIN_N; j++)
                pin_col_chan[2*j +: 2] <= {2{feeds_v[ROW_PIN_N+j] & pin_val[ROW_PIN_N+j]}};
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    property p_mc_clear;
        (mc_regd & mc_clr) != 16'h0000 |=> (mc_q & $past(mc_regd & mc_clr)) == 16'h0000;
    endproperty
    a_mc_clear: assert property (p_mc_clear) else $error("cleared macrocell did not go low");

    // start only outside reset: the release edge still loads zeros, not d_v
    property p_mc_comb;
        !rst |=> ((mc_q ^ $past(d_v)) & ~$past(mc_regd)) == 16'h0000;
    endproperty
    a_mc_comb: assert property (p_mc_comb) else $error("combinational macrocell did not follow");

    property p_mc_hold;
        1'b1 |=> ((mc_q ^ $past(mc_q)) & $past(mc_regd & ~mc_clr & ~mc_pre & ~(mc_clk & mc_ce))) == 16'h0000;
    endproperty
    a_mc_hold: assert property (p_mc_hold) else $error("macrocell register changed without clock");

    property p_gclk_load;
        mc_regd[0] && !mc_cfg[0].pt3_clk && !mc_cfg[0].pt2_ce && !mc_clr[0] && !mc_pre[0]
            && gclk_evt[mc_cfg[0].gclk_sel] |=> mc_q[0] == $past(d_v[0]);
    endproperty
    a_gclk_load: assert property (p_gclk_load) else $error("global clock did not load macrocell");

    property p_borrow;
        mc_cfg[1].borrow && sum_v[0] |-> sum_v[1];
    endproperty
    a_borrow: assert property (p_borrow) else $error("borrowed terms lost");

    property p_row4;
        rmux[0][1:0] == 2'h0 |=> row_out[0] == $past(mc_q[0]);
    endproperty
    a_row4: assert property (p_row4) else $error("row selector did not carry macrocell");

    property p_row3;
        rmux[0][1:0] != 2'h0 |=> !row_out[MC_NUM];
    endproperty
    a_row3: assert property (p_row3) else $error("spare row driven while shared selector busy");

    property p_oe;
        1'b1 |=> pin_oe == $past(drive_v) ##1 (pin_oe & $past(~drive_v)) == '0;
    endproperty
    a_oe: assert property (p_oe) else $error("pin enable does not match mode");

    property p_pin_clr;
        p_clr_v != '0 |=> (pin_reg & $past(p_clr_v)) == '0;
    endproperty
    a_pin_clr: assert property (p_pin_clr) else $error("pin register not cleared");

    c_gclk: cover property (mc_regd[0] && gclk_evt[0] ##1 mc_q[0]);
    c_borrow: cover property (mc_cfg[1].borrow && sum_v[0] && !own_sum[1]);
    c_bidir: cover property (pin_cfg[0].mode == MCF_PIN_BIDIR && pin_oe[0] ##1 !pin_oe[0]);
endmodule

// >>> testbench/mcf_board.sv
`timescale 1ns/100ps
module mcf_board
    import mcf_pkg::*;
#(
    parameter int N = ROW_PINS + COL_PINS
) (
    input  logic         core_clk,
    input  logic [N-1:0] pin_o,
    input  logic [N-1:0] pin_oe,
    input  logic [N-1:0] drv_val,
    input  logic [N-1:0] drv_en,
    output logic [N-1:0] pin_in
);
    logic [N-1:0] idle = '0;

    // a released wire has no pull, so it wanders every cycle
    always_ff @(posedge core_clk) begin
        idle <= ~idle;
    end

    // device driver first, then board driver, else the floating pattern
    always_comb begin
        for (int i = 0; i < N; i++) begin
            pin_in[i] = pin_oe[i] ? pin_o[i] : (drv_en[i] ? drv_val[i] : idle[i]);
        end
    end
endmodule

// >>> testbench/macrocell_io_cell_fabric_test.sv
`timescale 1ns/100ps
module macrocell_io_cell_fabric_test;
    import mcf_pkg::*;
    typedef struct {int src; int idx; logic [31:0] exp; string name;} mcf_note_t;
    logic        core_clk;
    logic        rst = 1'b1;
    logic [9:0]  reg_addr = '0;
    logic [31:0] reg_wdata = '0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic [3:0]  ded_in = '0;
    logic [32:0] row_in = '0;
    logic [47:0] col_in = '0;
    logic [31:0] row_out;
    logic [15:0] mc_out;
    logic [17:0] pin_in, pin_o, pin_oe, drv_val = '0, drv_en = '0;
    logic [15:0] pin_row_chan;
    logic [19:0] pin_col_chan;
    mcf_note_t   notes[$];
    int          failures = 0;
    int          checks = 0;
    int          seed = 32'hd963;
    logic        rd_d = 1'b0;
    logic        peek = 1'b0;

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    mcf_fabric u_dut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ded_in(ded_in), .row_in(row_in),
        .col_in(col_in), .row_out(row_out), .mc_out(mc_out), .pin_in(pin_in), .pin_o(pin_o),
        .pin_oe(pin_oe), .pin_row_chan(pin_row_chan), .pin_col_chan(pin_col_chan));
    mcf_board u_board (.core_clk(core_clk), .pin_o(pin_o), .pin_oe(pin_oe), .drv_val(drv_val),
        .drv_en(drv_en), .pin_in(pin_in));

    // ----------------------------------------
    // bus tasks and the result watcher
    // ----------------------------------------
    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic rd(input logic [9:0] a, input logic [31:0] e, input string n);
        reg_rd <= 1'b1;
        reg_addr <= a;
        notes.push_back('{0, 0, e, n});
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic look(input int src, input int idx, input logic e, input string n);
        peek <= 1'b1;
        notes.push_back('{src, idx, 32'(e), n});
        @(posedge core_clk);
        peek <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic settle();
        repeat (6) @(posedge core_clk);
    endtask

    task automatic end_of_test();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0 && notes.size() == 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // oldest note against the output it names
    always @(posedge core_clk) begin
        mcf_note_t   n;
        logic [31:0] got;
        rd_d <= reg_rd;
        if ((rd_d || peek) && notes.size() > 0) begin
            n = notes.pop_front();
            case (n.src)
                0: got = reg_rdata;
                1: got = 32'(row_out[n.idx]);
                2: got = 32'(pin_o[n.idx]);
                3: got = 32'(pin_oe[n.idx]);
                4: got = 32'(pin_row_chan[n.idx]);
                5: got = 32'(pin_col_chan[n.idx]);
                default: got = 32'(mc_out[n.idx]);
            endcase
            checks++;
            if (got !== n.exp) begin
                failures++;
                $display("BAD %s expected %h seen %h", n.name, n.exp, got);
            end
        end
    end

    // watchdog against a hang
    initial begin
        repeat (20000) @(posedge core_clk);
        failures++;
        end_of_test();
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        logic [9:0]  addrs [6] = '{A_MC, A_RMUX, A_PIN, A_PBUS, A_PT + 10'h003, 10'h300};
        logic [31:0] masks [6] = '{MC_CFG_MASK, RMUX_MASK, PIN_CFG_MASK, PBUS_MASK, PT_TOP_MASK, 32'h0};
        logic [47:0] cv;
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        // programmer budget of the smallest part
        checks++;
        if (PROGRAM_TEST_CLOCK_CYCLES != 2966000 || VERIFY_TEST_CLOCK_CYCLES != 1806000
            || PROGRAM_PULSE_TIME_S != 11.79) begin
            failures++;
            $display("BAD programmer budget expected %0d seen %0d", 2966000, PROGRAM_TEST_CLOCK_CYCLES);
        end
        // reset values, reserved bits and an unmapped word
        foreach (addrs[i]) begin
            rd(addrs[i], CFG_RST, "reset value");
            wr(addrs[i], 32'hffffffff);
            rd(addrs[i], masks[i], "masked readback");
        end
        // macrocell 0 sums row_in[0]; its other four terms never fire
        wr(A_PT + 10'h003, 32'h0);
        wr(A_PT, 32'h1);
        for (int p = 1; p < 5; p++) begin
            wr(10'(4 * p), 32'h1);
            wr(10'(4 * p + 1), 32'h2);
        end
        wr(A_RMUX, 32'h0);
        wr(A_PBUS, 32'h0);
        for (int k = 0; k < 4; k++) begin
            row_in <= {32'($random(seed)), k[0]};
            wr(A_MC, 32'(k[1]) << 1);
            settle();
            look(6, 0, k[0] ^ k[1], "mc_out comb");
            look(1, 0, k[0] ^ k[1], "row_out mc");
        end
        // registered on global clock 0, then the global clear wins
        wr(A_MC, 32'h101);
        row_in <= 33'h1;
        ded_in <= 4'h1;
        settle();
        look(6, 0, 1'b1, "mc_out clocked");
        row_in <= 33'h0;
        settle();
        look(6, 0, 1'b1, "mc_out held");
        ded_in <= 4'h4;
        settle();
        ded_in <= 4'h5;
        row_in <= 33'h1;
        settle();
        look(6, 0, 1'b0, "mc_out cleared");
        ded_in <= 4'h0;
        // both row selectors of macrocell 5
        for (int s = 0; s < 4; s++) begin
            cv = {16'($random(seed)), 32'($random(seed))};
            col_in <= cv;
            wr(A_RMUX + 10'h005, 32'(s == 0 ? 8 : s));
            settle();
            look(1, 5, s == 0 ? 1'b1 : cv[14 + s], "row_out 4-to-1");
            look(1, 21, s == 0 ? cv[17] : 1'b0, "row_out 3-to-1");
        end
        // column cell 0 output over all seventeen sources
        for (int s = 0; s < 17; s++) begin
            cv = {16'($random(seed)), 32'($random(seed))};
            col_in <= cv;
            wr(A_PIN + 10'h008, 32'((s << 3) | 1));
            settle();
            look(2, 8, cv[s], "column pin out");
            look(3, 8, 1'b1, "column pin drive");
        end
        // row cell 1 picks row 6, which carries column 18
        wr(A_RMUX + 10'h006, 32'h1);
        wr(A_PIN + 10'h001, 32'h11);
        wr(A_PIN + 10'h002, 32'h2);
        settle();
        look(2, 1, cv[18], "row pin out");
        // bidirectional enable from a dedicated pin, inputs onto channels
        for (int k = 0; k < 2; k++) begin
            ded_in <= 4'(k);
            drv_en <= 18'h00208;
            drv_val <= k[0] ? 18'h00208 : 18'h0;
            settle();
            look(3, 2, k[0], "bidir drive");
            look(4, 6, k[0], "row chan a");
            look(4, 7, k[0], "row chan b");
            look(5, 2, k[0], "col chan a");
            look(5, 3, k[0], "col chan b");
        end
        // row cell 1 through its register: clock line from pin 0, clear line from pin 1
        cv = {16'($random(seed)), 32'($random(seed))};
        col_in <= cv;
        ded_in <= 4'h0;
        wr(A_PBUS + 10'h013, 32'h1);
        wr(A_PIN + 10'h001, 32'h1c015);
        settle();
        ded_in <= 4'h1;
        settle();
        look(2, 1, cv[18], "pin reg load");
        col_in <= ~cv;
        settle();
        look(2, 1, cv[18], "pin reg hold");
        ded_in <= 4'h2;
        settle();
        look(2, 1, 1'b0, "pin reg clear");
        end_of_test();
    end
endmodule
